// [ar_pkg.sv]
// Package of constants and types for the autoreclose sequencer
// Operation
// RULE_01: Five states; reclosing only when enabled, reset, in-progress
// RULE_02: Disabled ignores initiates and never closes
// RULE_03: Reset state holds shot counter at zero
// RULE_04: Initiate enters in-progress until cycle finishes
// RULE_05: Lockout blocks closes and initiates until reset
// RULE_06: Program select chooses one of four programs
// RULE_07: Shot limit one to four per cycle
// RULE_08: Shots after first are always three-pole
// RULE_09: Limit one plus repeated initiate gives lockout
// RULE_10: Three-pole programs assert force-three-pole output
// RULE_11: Mixed program first timer chosen by initiate
// RULE_12: Later shots use three-pole timers two to four
// RULE_13: Single-pole program locks out on three-phase faults
// RULE_14: Variant A first shot uses three-pole timer one
// RULE_15: Variant A multiphase fault gives immediate lockout
// RULE_16: Variant B timer one, delayed initiate timer two
// RULE_17: Breaker order selects one, two, both, sequence
// RULE_18: Second breaker closes after confirmed delay
// RULE_19: Simultaneous mode closes both breakers together
// RULE_20: Protection trips initiate the cycle externally
// RULE_21: Time settings zero to maximum, 10 ms steps
// RULE_22: In-progress flag clears on close or lockout
// RULE_23: Incomplete-sequence timer expiry forces lockout
// RULE_24: Reset timer success returns to reset state
// RULE_25: Freeze stops dead timers, resume with timer two
// RULE_26: Extend input lengthens three-pole timer one
// RULE_27: Close increments counter; limit initiate locks out
package ar_pkg;
  // Timing base
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int TIME_STEP_MS    = 10;
  localparam int TICK_CYCLES     = TIME_STEP_MS * 1000000 / CLOCK_PERIOD_NS;
  localparam int TIME_W          = 16;
  localparam int SHOT_W          = 3;
  // Reclose programs
  localparam logic [1:0] PROG_MIXED = 2'h0;
  localparam logic [1:0] PROG_SP    = 2'h1;
  localparam logic [1:0] PROG_3PA   = 2'h2;
  localparam logic [1:0] PROG_3PB   = 2'h3;
  // Breaker order codes
  localparam logic [2:0] ORD_B1   = 3'h0;
  localparam logic [2:0] ORD_B2   = 3'h1;
  localparam logic [2:0] ORD_BOTH = 3'h2;
  localparam logic [2:0] ORD_1_2  = 3'h3;
  localparam logic [2:0] ORD_2_1  = 3'h4;
  // Reset values
  localparam logic [SHOT_W-1:0] SHOT_RESET = 3'h0;
  // Sequencer states
  typedef enum logic [2:0] {ST_DISABLED, ST_RESET, ST_RIP, ST_ENABLED, ST_LOCKOUT} state_t;
endpackage

// [autoreclose_sequencer.sv]
// Autoreclose sequencer: shot control, dead timers and breaker closing
`timescale 1ns/1ps
`default_nettype none
module autoreclose_sequencer
  import ar_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_resetn,
  // Settings
  input  wire logic              i_reclose_enable_setting,
  input  wire logic [1:0]        i_reclose_program_select,
  input  wire logic [2:0]        i_max_shot_limit,
  input  wire logic [2:0]        i_breaker_order_select,
  input  wire logic [TIME_W-1:0] i_single_pole_dead_timer,
  input  wire logic [TIME_W-1:0] i_three_pole_dead_timer_1,
  input  wire logic [TIME_W-1:0] i_three_pole_dead_timer_2,
  input  wire logic [TIME_W-1:0] i_three_pole_dead_timer_3,
  input  wire logic [TIME_W-1:0] i_three_pole_dead_timer_4,
  input  wire logic [TIME_W-1:0] i_dead_time_extension_value,
  input  wire logic [TIME_W-1:0] i_second_breaker_delay,
  input  wire logic [TIME_W-1:0] i_success_reset_delay,
  input  wire logic [TIME_W-1:0] i_sequence_timeout,
  // Protection and breaker inputs
  input  wire logic              i_single_pole_initiate,
  input  wire logic              i_three_pole_initiate,
  input  wire logic              i_three_pole_delayed_initiate,
  input  wire logic              i_multiphase_fault_input,
  input  wire logic              i_breaker_three_pole_open,
  input  wire logic              i_breaker_closed,
  input  wire logic              i_dead_time_extend_input,
  input  wire logic              i_cycle_freeze_input,
  input  wire logic              i_reclose_reset,
  // Outputs
  output logic                   o_close_breaker_1,
  output logic                   o_close_breaker_2,
  output logic                   o_reclose_in_progress_flag,
  output logic                   o_force_three_pole_output,
  output logic                   o_lockout_outcome,
  output logic [SHOT_W-1:0]      o_shot_count
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [8:0] meta_reg;
  logic [8:0] pin_reg;
  logic sp_in, tp_in, td_in, multi_in, b3p_open, bkr_closed, ext_in, freeze_in, rst_in;

  // Two stages for every pin input
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      meta_reg <= 9'h000;
      pin_reg  <= 9'h000;
    end
    else
    begin
      meta_reg <= {i_single_pole_initiate, i_three_pole_initiate,
                   i_three_pole_delayed_initiate, i_multiphase_fault_input,
                   i_breaker_three_pole_open, i_breaker_closed,
                   i_dead_time_extend_input, i_cycle_freeze_input, i_reclose_reset};
      pin_reg  <= meta_reg;
    end
  end

  assign {sp_in, tp_in, td_in, multi_in, b3p_open, bkr_closed, ext_in, freeze_in, rst_in} = pin_reg;

  // ----------------------------------------
  // State and registers
  // ----------------------------------------
  state_t              state_reg, state_next;
  logic [SHOT_W-1:0]   shot_reg, shot_next;
  logic                init_d_reg, freeze_d_reg;
  logic                tp1_reg, ext_seen_reg, ext_done_reg;
  logic                close1_reg, close1_next, close2_reg, close2_next;
  logic                rip_reg, force_reg, lock_reg;
  logic                tick;
  logic                dead_exp, seq_exp, reset_exp, xfer_exp;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire en        = i_reclose_enable_setting;
  wire [1:0] prog = i_reclose_program_select;
  wire init_any  = sp_in | tp_in | td_in;
  wire init_evt  = init_any & ~init_d_reg;
  wire idle      = (state_reg == ST_RESET) || (state_reg == ST_ENABLED);
  wire take_init = en & idle & init_evt;                                          // RULE_02
  wire at_limit  = ({1'b0, shot_reg} >= {1'b0, i_max_shot_limit});               // RULE_27
  wire first     = (shot_reg == SHOT_RESET);

  // First-shot lockout per program
  wire first_lock = ((prog == PROG_SP) & (multi_in | tp_in | td_in | b3p_open))  // RULE_13
                  | ((prog == PROG_3PA) & multi_in);                              // RULE_15
  wire init_lock  = at_limit | (first & first_lock);                             // RULE_09

  // First-shot timer selection
  wire [TIME_W-1:0] mixed_val = td_in ? i_three_pole_dead_timer_2 :
                                tp_in ? i_three_pole_dead_timer_1 :
                                        i_single_pole_dead_timer;                  // RULE_11
  wire [TIME_W-1:0] b_val     = td_in ? i_three_pole_dead_timer_2 :
                                        i_three_pole_dead_timer_1;                 // RULE_16
  wire [TIME_W-1:0] first_val = (prog == PROG_MIXED) ? mixed_val :
                                (prog == PROG_SP)    ? i_single_pole_dead_timer :
                                (prog == PROG_3PA)   ? i_three_pole_dead_timer_1 : // RULE_14
                                                       b_val;                       // RULE_06
  wire first_tp1 = ((prog == PROG_MIXED) & tp_in & ~td_in) | (prog == PROG_3PA)
                 | ((prog == PROG_3PB) & ~td_in);
  // Later shots are three-pole on timers two to four
  wire [TIME_W-1:0] later_val = (shot_reg == 3'h1) ? i_three_pole_dead_timer_2 :
                                (shot_reg == 3'h2) ? i_three_pole_dead_timer_3 :
                                                     i_three_pole_dead_timer_4;     // RULE_08 RULE_12

  // Dead timer control
  wire in_rip      = (state_reg == ST_RIP);
  wire start_new   = take_init & ~init_lock;                                      // RULE_04
  wire resume      = in_rip & ~freeze_in & freeze_d_reg;                           // RULE_25
  wire ext_pending = tp1_reg & ext_seen_reg & ~ext_done_reg;
  wire extend_go   = in_rip & dead_exp & ext_pending;                              // RULE_26
  wire dead_done   = in_rip & dead_exp & ~ext_pending;
  wire dead_start  = start_new | resume | extend_go;
  wire [TIME_W-1:0] dead_value = resume    ? i_three_pole_dead_timer_2 :
                                 extend_go ? i_dead_time_extension_value :
                                 first     ? first_val : later_val;
  wire rip_lock    = seq_exp                                                       // RULE_23
                   | ((prog == PROG_SP) & first & b3p_open);                       // RULE_13

  // Breaker order and transfer
  wire ord_b1   = (i_breaker_order_select == ORD_B1);
  wire ord_b2   = (i_breaker_order_select == ORD_B2);
  wire ord_both = (i_breaker_order_select == ORD_BOTH);                           // RULE_19
  wire ord_12   = (i_breaker_order_select == ORD_1_2);
  wire ord_21   = (i_breaker_order_select == ORD_2_1);
  wire xfer_go  = (state_reg == ST_ENABLED) & xfer_exp & bkr_closed;              // RULE_18
  wire close1_set = (dead_done & (ord_b1 | ord_both | ord_12)) | (xfer_go & ord_21); // RULE_17
  wire close2_set = (dead_done & (ord_b2 | ord_both | ord_21)) | (xfer_go & ord_12); // RULE_17

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Cycle sequencing across the five states
  always_comb
  begin
    state_next = state_reg;
    if (!en)
      state_next = ST_DISABLED;                                                   // RULE_02
    else
    begin
      case (state_reg)
        ST_DISABLED: state_next = ST_RESET;
        ST_RESET, ST_ENABLED:
        begin
          if (take_init)
            state_next = init_lock ? ST_LOCKOUT : ST_RIP;                         // RULE_07
          else if (state_reg == ST_ENABLED && reset_exp)
            state_next = (bkr_closed && !init_any) ? ST_RESET : ST_LOCKOUT;       // RULE_24
        end
        ST_RIP:
        begin
          if (rip_lock)
            state_next = ST_LOCKOUT;
          else if (dead_done)
            state_next = ST_ENABLED;
        end
        ST_LOCKOUT:
        begin
          if (rst_in)
            state_next = ST_RESET;                                                // RULE_05
        end
        default: state_next = ST_DISABLED;                                        // RULE_01
      endcase
    end
  end

  // Counter and output values
  assign shot_next   = (state_next == ST_RESET) ? SHOT_RESET :                      // RULE_03
                       dead_done ? SHOT_W'(shot_reg + 3'h1) : shot_reg;            // RULE_27
  assign close1_next = (state_next == ST_ENABLED) & (close1_set | (close1_reg & ~bkr_closed));
  assign close2_next = (state_next == ST_ENABLED) & (close2_set | (close2_reg & ~bkr_closed));

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      state_reg    <= ST_DISABLED;
      shot_reg     <= SHOT_RESET;
      init_d_reg   <= 1'b0;
      freeze_d_reg <= 1'b0;
      close1_reg   <= 1'b0;
      close2_reg   <= 1'b0;
      rip_reg      <= 1'b0;
      force_reg    <= 1'b0;
      lock_reg     <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      shot_reg     <= shot_next;
      init_d_reg   <= init_any;
      freeze_d_reg <= freeze_in;
      close1_reg   <= close1_next;
      close2_reg   <= close2_next;
      rip_reg      <= (state_next == ST_RIP);                                     // RULE_22
      force_reg    <= en & (prog[1] | (shot_next != SHOT_RESET));                 // RULE_10
      lock_reg     <= (state_next == ST_LOCKOUT);
    end
  end

  // Extension tracking for three-pole timer one
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      tp1_reg      <= 1'b0;
      ext_seen_reg <= 1'b0;
      ext_done_reg <= 1'b0;
    end
    else if (start_new || resume)
    begin
      tp1_reg      <= start_new & first & first_tp1;
      ext_seen_reg <= 1'b0;
      ext_done_reg <= 1'b0;
    end
    else
    begin
      ext_seen_reg <= ext_seen_reg | (in_rip & tp1_reg & ext_in);                  // RULE_26
      ext_done_reg <= ext_done_reg | extend_go;
    end
  end

  // ----------------------------------------
  // Timers, all on the 10 ms base
  // ----------------------------------------
  tick_divider #(.CYCLES(TICK_DIV)) u_tick (
    .i_clock (i_clock),
    .i_resetn(i_resetn),
    .o_tick  (tick)                                                               // RULE_21
  );

  interval_timer #(.W(TIME_W)) u_dead (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_tick(tick),
    .i_start(dead_start), .i_stop(state_next != ST_RIP), .i_hold(freeze_in),       // RULE_25
    .i_value(dead_value), .o_busy(), .o_expired(dead_exp)
  );

  interval_timer #(.W(TIME_W)) u_seq (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_tick(tick),
    .i_start(start_new), .i_stop(state_next != ST_RIP), .i_hold(1'b0),             // RULE_23
    .i_value(i_sequence_timeout), .o_busy(), .o_expired(seq_exp)
  );

  interval_timer #(.W(TIME_W)) u_reset (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_tick(tick),
    .i_start(dead_done), .i_stop(state_next != ST_ENABLED), .i_hold(1'b0),         // RULE_24
    .i_value(i_success_reset_delay), .o_busy(), .o_expired(reset_exp)
  );

  interval_timer #(.W(TIME_W)) u_xfer (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_tick(tick),
    .i_start(dead_done & (ord_12 | ord_21)), .i_stop(state_next != ST_ENABLED),     // RULE_18
    .i_hold(1'b0), .i_value(i_second_breaker_delay),
    .o_busy(), .o_expired(xfer_exp)
  );

  // Outputs straight from flip-flops
  assign o_close_breaker_1          = close1_reg;
  assign o_close_breaker_2          = close2_reg;
  assign o_reclose_in_progress_flag = rip_reg;
  assign o_force_three_pole_output  = force_reg;
  assign o_lockout_outcome          = lock_reg;
  assign o_shot_count               = shot_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_close_rise;
    $rose(close1_reg | close2_reg);
  endsequence
  sequence s_shot_close;
    (state_reg == ST_RIP) ##1 (state_reg == ST_ENABLED);
  endsequence

  AST_DISABLED_NO_CLOSE: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE_02
    !en |=> !close1_reg && !close2_reg && state_reg == ST_DISABLED)
    else $error("close or activity while disabled");
  AST_RESET_ZERO: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE_03
    state_reg == ST_RESET |-> shot_reg == SHOT_RESET)
    else $error("shot counter not zero in reset");
  AST_INIT_TO_RIP: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE_04
    start_new |=> state_reg == ST_RIP && rip_reg)
    else $error("initiate did not enter reclose in progress");
  AST_LOCKOUT_HOLD: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE_05
    state_reg == ST_LOCKOUT && en && !rst_in |=> state_reg == ST_LOCKOUT && !close1_reg)
    else $error("lockout left without reset");
  AST_SHOT_LIMIT: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE_07
    take_init && at_limit |=> lock_reg ##1 !$rose(close1_reg))
    else $error("initiate at shot limit not locked out");
  AST_MAX_ONE: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE_09
    i_max_shot_limit == 3'h1 && shot_reg == 3'h1 && take_init |=> state_reg == ST_LOCKOUT)
    else $error("single shot limit did not lock out");
  AST_FORCE_3P: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE_10
    en && prog[1] |=> force_reg)
    else $error("force three pole missing in three pole program");
  AST_RIP_CLEAR: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE_22
    s_close_rise |-> !rip_reg)
    else $error("in progress flag held across close");
  AST_SEQ_TIMEOUT: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE_23
    in_rip && seq_exp && en |=> lock_reg && state_reg == ST_LOCKOUT)
    else $error("incomplete sequence did not lock out");
  AST_FREEZE: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE_25
    in_rip && freeze_d_reg |-> !dead_exp)
    else $error("dead timer expired while frozen");
  AST_SHOT_INC: assert property (@(posedge i_clock) disable iff (!i_resetn) // RULE_27
    s_shot_close |-> shot_reg == SHOT_W'($past(shot_reg) + 3'h1))
    else $error("shot counter did not step on close");
endmodule
`default_nettype wire

// [autoreclose_sequencer_tb.sv]
// Self-checking bench for the autoreclose sequencer
`timescale 1ns/1ps
`default_nettype none
module autoreclose_sequencer_tb;
  import ar_pkg::*;
  logic i_clock = 1'b0, i_resetn = 1'b0, i_reclose_enable_setting = 1'b1;
  logic i_reclose_reset = 1'b0, i_dead_time_extend_input = 1'b0, i_cycle_freeze_input = 1'b0;
  logic [1:0] i_reclose_program_select = PROG_MIXED, trip_kind = 2'h0;
  logic [2:0] i_max_shot_limit = 3'h1, i_breaker_order_select = ORD_B1;
  logic [TIME_W-1:0] i_single_pole_dead_timer = 16'h0002, i_three_pole_dead_timer_1 = 16'h0003;
  logic [TIME_W-1:0] i_three_pole_dead_timer_2 = 16'h0002, i_three_pole_dead_timer_3 = 16'h0002;
  logic [TIME_W-1:0] i_three_pole_dead_timer_4 = 16'h0002, i_dead_time_extension_value = 16'h0001;
  logic [TIME_W-1:0] i_second_breaker_delay = 16'h0002, i_success_reset_delay = 16'h0005;
  logic [TIME_W-1:0] i_sequence_timeout = 16'h0030;
  logic i_single_pole_initiate, i_three_pole_initiate, i_three_pole_delayed_initiate;
  logic i_multiphase_fault_input, i_breaker_three_pole_open, i_breaker_closed;
  logic o_close_breaker_1, o_close_breaker_2, o_reclose_in_progress_flag;
  logic o_force_three_pole_output, o_lockout_outcome;
  logic [SHOT_W-1:0] o_shot_count;
  int mismatches = 0, check_count = 0, cycles = 0;

  autoreclose_sequencer #(.TICK_DIV(10)) u_dut
  (
    .i_clock, .i_resetn, .i_reclose_enable_setting, .i_reclose_program_select,
    .i_max_shot_limit, .i_breaker_order_select, .i_single_pole_dead_timer,
    .i_three_pole_dead_timer_1, .i_three_pole_dead_timer_2, .i_three_pole_dead_timer_3,
    .i_three_pole_dead_timer_4, .i_dead_time_extension_value, .i_second_breaker_delay,
    .i_success_reset_delay, .i_sequence_timeout, .i_single_pole_initiate,
    .i_three_pole_initiate, .i_three_pole_delayed_initiate, .i_multiphase_fault_input,
    .i_breaker_three_pole_open, .i_breaker_closed, .i_dead_time_extend_input,
    .i_cycle_freeze_input, .i_reclose_reset, .o_close_breaker_1, .o_close_breaker_2,
    .o_reclose_in_progress_flag, .o_force_three_pole_output, .o_lockout_outcome, .o_shot_count
  );

  trip_breaker_model u_partner
  (
    .i_clock, .i_resetn, .i_trip_kind(trip_kind), .i_close_1(o_close_breaker_1),
    .i_close_2(o_close_breaker_2), .o_single_init(i_single_pole_initiate),
    .o_three_init(i_three_pole_initiate), .o_delayed_init(i_three_pole_delayed_initiate),
    .o_multiphase(i_multiphase_fault_input), .o_three_open(i_breaker_three_pole_open),
    .o_closed(i_breaker_closed)
  );

  // Clock and hang limit
  always #5 i_clock = ~i_clock;
  always @(posedge i_clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string name, input logic [2:0] exp, input logic [2:0] got);
    #1;
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return o_close_breaker_1;
      1: return o_close_breaker_2;
      2: return o_lockout_outcome;
      3: return o_close_breaker_1 | o_close_breaker_2;
      default: return o_shot_count === SHOT_RESET;
    endcase
  endfunction

  // Waits a bounded number of cycles for a chosen output
  task automatic wait_for(input int k, input int lim);
    int n;
    n = 0;
    #1;
    while (pick(k) !== 1'b1 && n < lim)
    begin
      @(posedge i_clock);
      #1;
      n++;
    end
    check($sformatf("wait %0d", k), 3'h0, 3'(n >= lim));
  endtask

  task automatic trip(input logic [1:0] kind);
    @(posedge i_clock);
    trip_kind <= kind;
    repeat (3) @(posedge i_clock);
    trip_kind <= 2'h0;
  endtask

  task automatic clear_lockout();
    @(posedge i_clock);
    i_reclose_reset <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_reclose_reset <= 1'b0;
    repeat (4) @(posedge i_clock);
    check("lockout", 3'h0, 3'(o_lockout_outcome));
    check("shots", 3'h0, o_shot_count);
  endtask

  // Disabled scheme ignores a trip
  task automatic t_disabled();
    @(posedge i_clock);
    i_reclose_enable_setting <= 1'b0;
    trip(2'h1);
    repeat (60) @(posedge i_clock);
    check("close 1", 3'h0, 3'(o_close_breaker_1));
    check("flag", 3'h0, 3'(o_reclose_in_progress_flag));
    i_reclose_enable_setting <= 1'b1;
  endtask

  // One-shot limit: reclose once, then lock out on the next trip
  task automatic t_one_shot();
    trip(2'h1);
    repeat (3) @(posedge i_clock);
    check("flag", 3'h1, 3'(o_reclose_in_progress_flag));
    wait_for(0, 200);
    check("shots", 3'h1, o_shot_count);
    check("flag", 3'h0, 3'(o_reclose_in_progress_flag));
    check("close 2", 3'h0, 3'(o_close_breaker_2));
    repeat (10) @(posedge i_clock);
    check("force", 3'h1, 3'(o_force_three_pole_output));
    trip(2'h1);
    wait_for(2, 50);
    trip(2'h2);
    repeat (60) @(posedge i_clock);
    check("close 1", 3'h0, 3'(o_close_breaker_1));
    clear_lockout();
  endtask

  // Single and simultaneous breaker choices, each ending in a successful reset
  task automatic t_orders();
    logic [2:0] ords [3] = '{ORD_B1, ORD_B2, ORD_BOTH};
    for (int k = 0; k < 3; k++)
    begin
      @(posedge i_clock);
      i_max_shot_limit <= 3'h2;
      i_breaker_order_select <= ords[k];
      trip(2'h2);
      wait_for(3, 200);
      check("close 1", 3'(k != 1), 3'(o_close_breaker_1));
      check("close 2", 3'(k != 0), 3'(o_close_breaker_2));
      wait_for(4, 300);
      check("lockout", 3'h0, 3'(o_lockout_outcome));
    end
  endtask

  // Sequential closing in both orders
  task automatic t_sequence();
    for (int k = 0; k < 2; k++)
    begin
      @(posedge i_clock);
      i_breaker_order_select <= (k == 0) ? ORD_1_2 : ORD_2_1;
      trip(2'h1);
      wait_for(k, 200);
      check("other close", 3'h0, 3'(k == 0 ? o_close_breaker_2 : o_close_breaker_1));
      wait_for(1 - k, 100);
      wait_for(4, 300);
    end
  endtask

  // Force output per program, multiphase lockouts, freeze resume, sequence timeout
  task automatic t_programs();
    for (int p = 0; p < 4; p++)
    begin
      @(posedge i_clock);
      i_reclose_program_select <= 2'(p);
      repeat (4) @(posedge i_clock);
      check("force", 3'(p >= 2), 3'(o_force_three_pole_output));
    end
    for (int p = 1; p < 3; p++)
    begin
      i_reclose_program_select <= 2'(p);
      trip(2'h2);
      wait_for(2, 50);
      check("close 1", 3'h0, 3'(o_close_breaker_1));
      clear_lockout();
    end
    i_reclose_program_select <= PROG_MIXED;
    i_single_pole_dead_timer <= 16'h0200;
    i_cycle_freeze_input <= 1'b1;
    trip(2'h1);
    i_cycle_freeze_input <= 1'b0;
    wait_for(3, 60);
    wait_for(4, 300);
    i_sequence_timeout <= 16'h0003;
    trip(2'h1);
    wait_for(2, 100);
    check("close 1", 3'h0, 3'(o_close_breaker_1));
    clear_lockout();
  endtask

  initial
  begin
    repeat (3) @(posedge i_clock);
    i_resetn <= 1'b1;
    t_disabled();
    t_one_shot();
    t_orders();
    t_sequence();
    t_programs();
    stop_test();
  end
endmodule
`default_nettype wire

// [interval_timer.sv]
// Loadable down-counting timer in tick units
`timescale 1ns/1ps
`default_nettype none
module interval_timer
#(
  parameter int W = 16
)
(
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_resetn,
  // Control
  input  wire logic         i_tick,
  input  wire logic         i_start,
  input  wire logic         i_stop,
  input  wire logic         i_hold,
  input  wire logic [W-1:0] i_value,
  // Status
  output logic              o_busy,
  output logic              o_expired
);
  logic [W-1:0] count_reg;
  logic         busy_reg;
  logic         exp_reg;

  generate
    if (W < 1)
    begin : g_chk
      $error("interval_timer width must be positive");
    end
  endgenerate

  // Load, count down on ticks unless held, pulse at zero
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      count_reg <= '0;
      busy_reg  <= 1'b0;
      exp_reg   <= 1'b0;
    end
    else
    begin
      exp_reg <= 1'b0;
      if (i_start)
      begin
        count_reg <= i_value;
        busy_reg  <= 1'b1;
      end
      else if (i_stop)
        busy_reg <= 1'b0;
      else if (busy_reg && i_tick && !i_hold)
      begin
        if (count_reg == '0)
        begin
          busy_reg <= 1'b0;
          exp_reg  <= 1'b1;
        end
        else
          count_reg <= count_reg - 1'b1;
      end
    end
  end

  assign o_busy    = busy_reg;
  assign o_expired = exp_reg;
endmodule
`default_nettype wire

// [tick_divider.sv]
// Divider producing the 10 ms timing enable
`timescale 1ns/1ps
`default_nettype none
module tick_divider
#(
  parameter int unsigned CYCLES = 1000000
)
(
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_resetn,
  // Enable pulse
  output logic      o_tick
);
  logic [31:0] count_reg;
  logic        tick_reg;

  generate
    if (CYCLES < 2)
    begin : g_chk
      $error("tick_divider needs at least two cycles");
    end
  endgenerate

  // Free running count, one pulse per period
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      count_reg <= 32'h0;
      tick_reg  <= 1'b0;
    end
    else
    begin
      tick_reg  <= (count_reg == CYCLES - 1);
      count_reg <= (count_reg == CYCLES - 1) ? 32'h0 : count_reg + 32'h1;
    end
  end

  assign o_tick = tick_reg;
endmodule
`default_nettype wire

// [trip_breaker_model.sv]
// Partner model: protection trip outputs and a breaker pair sharing one closed contact
`timescale 1ns/1ps
`default_nettype none
module trip_breaker_model
#(
  parameter int CLOSE_CYCLES = 3
)
(
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  // Fault kind from the bench: 0 none, 1 one phase, 2 multiphase, 3 delayed
  input  wire logic [1:0] i_trip_kind,
  // Close commands
  input  wire logic       i_close_1,
  input  wire logic       i_close_2,
  // Protection and breaker state
  output logic            o_single_init,
  output logic            o_three_init,
  output logic            o_delayed_init,
  output logic            o_multiphase,
  output logic            o_three_open,
  output logic            o_closed
);
  logic [3:0] delay_reg;
  logic       closed_reg;

  // Single-pole trip for one phase, three-pole trip otherwise
  assign o_single_init  = (i_trip_kind == 2'h1);
  assign o_three_init   = (i_trip_kind == 2'h2);
  assign o_delayed_init = (i_trip_kind == 2'h3);
  assign o_multiphase   = i_trip_kind[1];
  assign o_three_open   = ~closed_reg & i_trip_kind[1];
  assign o_closed       = closed_reg;

  // Breaker opens on any trip and closes a few cycles into a close command
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn || i_trip_kind != 2'h0)
    begin
      closed_reg <= !i_resetn;
      delay_reg  <= 4'h0;
    end
    else if ((i_close_1 || i_close_2) && delay_reg == 4'(CLOSE_CYCLES))
      closed_reg <= 1'b1;
    else
      delay_reg <= (i_close_1 || i_close_2) ? delay_reg + 4'h1 : 4'h0;
  end
endmodule
`default_nettype wire
